/* sim/open_load_on_summary_flag_diag_loop_tb.sv */
// Self-checking bench for the open-load-on diagnosis loop.
// Assumes the design files and the plant model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "open_load_on_summary_flag_cfg.svh"
module open_load_on_summary_flag_diag_loop_tb;
    import open_load_on_summary_flag_pkg::*;
    localparam int ST = 20, SW = 10, PM = 40, SY = 2;
    logic        ref_clk = 1'b0, srst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, ol_comp, mux_en, flag, busy;
    logic [15:0] pwm_map = 16'h000f;
    logic [7:0]  ch_on, res, open_mask = 8'h00, dc_on = 8'hef;
    logic [7:0]  pwm_mask = 8'h00, short_mask = 8'h00;
    logic [2:0]  mux_ch, seq[$];
    logic        busy_p = 1'b0;
    int          dw[$], n_mismatch = 0, n_tests = 0;
    always #2 ref_clk = ~ref_clk;
    open_load_on_summary_flag_diag_loop #(.SETTLE_CYC(16'(ST)), .SWITCH_CYC(16'(SW)),
        .PREMUX_CYC(16'(PM)), .SYNC_CYC(16'(SY))) DUT (
        .ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ch_on(ch_on), .pwm_map(pwm_map), .ol_comp(ol_comp),
        .mux_ch(mux_ch), .mux_en(mux_en),
        .open_load_on_result_bits(res),
        .open_load_on_summary_flag(flag), .loop_busy(busy));
    open_load_on_summary_flag_plant plant (.ref_clk(ref_clk), .mux_ch(mux_ch),
        .open_mask(open_mask), .dc_on(dc_on), .pwm_mask(pwm_mask),
        .short_mask(short_mask), .ch_on(ch_on), .ol_comp(ol_comp));
    ////////////////////////////////////////////////////////////////////
    // Records each channel the loop visits and how long it stays there
    always @(posedge ref_clk) begin
        if (busy === 1'b1 && (busy_p !== 1'b1 || mux_ch !== seq[$])) begin
            seq.push_back(mux_ch);
            dw.push_back(1);
        end else if (busy === 1'b1) dw[$] = dw[$] + 1;
        busy_p <= busy;
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic run_loop(input logic [7:0] er, input logic [2:0] ord[$],
                            input logic dir);
        int i;
        seq.delete(); dw.delete(); i = 0;
        apb(`ADDR_SEL, 1'b1, 32'h0000000a);
        apb(`ADDR_SEL, 1'b0, 32'h0);
        chk("sel_run", rd, 32'h0000000a);
        chk("mux_en_run", {31'h0, mux_en}, 32'h1);
        while (busy !== 1'b0 && i < 5000) begin @(posedge ref_clk); i++; end
        chk("busy_end", {31'h0, busy}, 32'h0);
        chk("result", {24'h0, res}, {24'h0, er});
        chk("flag", {31'h0, flag}, {31'h0, |er});
        chk("mux_en_end", {31'h0, mux_en}, 32'h0);
        apb(`ADDR_SEL, 1'b0, 32'h0);
        chk("sel_end", rd, 32'h0000000f);
        chk("visits", seq.size(), ord.size());
        foreach (ord[k]) chk("order", {29'h0, seq[k]}, {29'h0, ord[k]});
        if (dir) begin
            chk("settle", 32'(dw[0] inside {[ST+SY:ST+SY+6]}), 32'h1);
            for (i = 1; i < dw.size(); i++)
                chk("switch", 32'(dw[i] inside {[SW+SY:SW+SY+4]}), 32'h1);
        end
    endtask
    task automatic t_reset();
        apb(`ADDR_SEL, 1'b0, 32'h0);
        chk("sel_rst", rd, 32'h0000000f);
        apb(`ADDR_STAT, 1'b0, 32'h0);
        chk("stat_rst", rd, 32'h0);
        apb(12'h00c, 1'b0, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        apb(`ADDR_RES, 1'b1, 32'h000000ff);
        apb(`ADDR_RES, 1'b0, 32'h0);
        chk("res_ro", rd, 32'h0);
    endtask
    task automatic t_direct();
        open_mask <= 8'h58;
        run_loop(8'h48, '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7}, 1'b1);
        open_mask <= 8'h00;
        repeat (50) @(posedge ref_clk);
        chk("hold_res", {24'h0, res}, 32'h48);
        chk("hold_flag", {31'h0, flag}, 32'h1);
        run_loop(8'h00, '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7}, 1'b1);
    endtask
    task automatic t_pwm();
        pwm_map <= 16'he78f;
        pwm_mask <= 8'h68;
        short_mask <= 8'h40;
        open_mask <= 8'h64;
        run_loop(8'h24, '{3'h2, 3'h5, 3'h3, 3'h6}, 1'b0);
    endtask
    task automatic t_single();
        // Channel 3 held on steadily; comparator settles before the read
        pwm_mask <= 8'h00;
        short_mask <= 8'h00;
        open_mask <= 8'h08;
        apb(`ADDR_SEL, 1'b1, 32'h00000003);
        repeat (ST) @(posedge ref_clk);
        apb(`ADDR_RES, 1'b0, 32'h0);
        chk("single_res", rd, 32'h00000008);
        chk("single_flag", {31'h0, flag}, 32'h1);
        apb(`ADDR_SEL, 1'b1, 32'h00000001);
        apb(`ADDR_SEL, 1'b0, 32'h0);
        chk("rsvd_flag", {31'h0, flag}, 32'h0);
        open_mask <= 8'h00;
        apb(`ADDR_SEL, 1'b1, 32'h00000003);
        repeat (ST) @(posedge ref_clk);
        apb(`ADDR_RES, 1'b0, 32'h0);
        chk("single_clr", rd, 32'h0);
        chk("single_flag0", {31'h0, flag}, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_direct();
        t_pwm();
        t_single();
        final_report();
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        n_mismatch++;
        final_report();
    end
endmodule // open_load_on_summary_flag_diag_loop_tb
`default_nettype wire

/* sim/open_load_on_summary_flag_plant.sv */
// Load and PWM model behind the sequencer's channel inputs.
// Assumes one clock shared with the sequencer.
`timescale 1ns/1ps
`default_nettype none
module open_load_on_summary_flag_plant (
    input  wire logic       ref_clk,
    input  wire logic [2:0] mux_ch,
    input  wire logic [7:0] open_mask,
    input  wire logic [7:0] dc_on,
    input  wire logic [7:0] pwm_mask,
    input  wire logic [7:0] short_mask,
    output logic      [7:0] ch_on,
    output logic            ol_comp
);
    logic [7:0] cnt = 8'h00;
    logic [7:0] pon;
    always @(posedge ref_clk) cnt <= (cnt == 8'h95) ? 8'h00 : cnt + 8'h01;
    // Short channels stay on less than pre-mux wait plus switch delay
    assign pon = short_mask & {8{cnt < 8'h14}}
               | ~short_mask & {8{cnt < 8'h64}};
    // Direct channels are held at their dc_on level before and during each loop
    assign ch_on = dc_on & ~pwm_mask | pwm_mask & pon;
    // The comparator can only report an open load on a channel that is on
    initial ol_comp = 1'b0;
    always @(posedge ref_clk) ol_comp <= open_mask[mux_ch] & ch_on[mux_ch];
endmodule // open_load_on_summary_flag_plant
`default_nettype wire

/* verilog/open_load_on_summary_flag_cfg.svh */
// Constants of the open-load-while-on diagnosis sequencer.
// Included by the package, the interfaces and every design module.
`ifndef OPEN_LOAD_ON_SUMMARY_FLAG_CFG_SVH
`define OPEN_LOAD_ON_SUMMARY_FLAG_CFG_SVH

`define NCH           8
`define CH_W          3
`define SEL_W         4
`define CNT_W         16
`define ADDR_W        12
`define SEL_LOOP      4'ha
`define SEL_IDLE      4'hf
`define SEL_CH_LO     4'h2
`define SEL_CH_HI     4'h7
`define HS_FIRST      4'h2
`define FROM_NONE     4'h8
`define NO_PICK       4'h0
`define CH_STEP       4'h1
`define MAP_W         2
`define MAP_DIRECT    2'h0
`define MAP_GEN0      2'h1
`define MAP_GEN1      2'h2
`define CLK_PERIOD_NS 4
`define NS_PER_US     1000
`define SETTLE_MAX_US 40
`define SWITCH_MAX_US 20
`define PREMUX_MAX_US 76
`define SYNC_CYC      2
`define CNT_LAST      16'h0001
`define ADDR_SEL      12'h000
`define ADDR_RES      12'h004
`define ADDR_STAT     12'h008
`define STAT_BUSY_BIT 1
`define STAT_CH_LSB   4

`endif

/* verilog/open_load_on_summary_flag_ch_monitor.sv */
// Watches the on state of the channel under the multiplexer and the
// comparator; reports a switch-on of that same channel as a pulse.
`timescale 1ns/1ps
`default_nettype none
`include "open_load_on_summary_flag_cfg.svh"

module open_load_on_summary_flag_ch_monitor
    import open_load_on_summary_flag_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            srst,
    input  wire logic [`NCH-1:0] ch_on,
    input  wire logic            ol_comp,
    mux_if.mon                   mif
);
    mon_reg_t q;
    mon_reg_t d;

    always_comb begin
        d         = q;
        d.ch_prev = mif.ch;
        d.on_prev = ch_on[mif.ch];
        // A change of channel never counts as a switch-on
        d.rise    = ch_on[mif.ch] & ~q.on_prev & (q.ch_prev == mif.ch);
        d.comp    = ol_comp;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign mif.on_rise = q.rise;
    assign mif.comp    = q.comp;

endmodule // open_load_on_summary_flag_ch_monitor

`default_nettype wire

/* verilog/open_load_on_summary_flag_delay_timer.sv */
// Down counter for settling, switching, pre-mux and re-timing delays.
// A load pulse starts it; done pulses once the count has run out.
`timescale 1ns/1ps
`default_nettype none
`include "open_load_on_summary_flag_cfg.svh"

module open_load_on_summary_flag_delay_timer
    import open_load_on_summary_flag_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic srst,
    delay_if.timer    tif
);
    timer_reg_t q;
    timer_reg_t d;

    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (tif.load) begin
            d.cnt = tif.count;
            d.run = 1'b1;
        end else if (q.run) begin
            if (q.cnt <= `CNT_LAST) begin
                d.run  = 1'b0;
                d.done = 1'b1;
            end else begin
                d.cnt = q.cnt - `CNT_LAST;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tif.done = q.done;

endmodule // open_load_on_summary_flag_delay_timer

`default_nettype wire

/* verilog/open_load_on_summary_flag_diag_loop.sv */
// Open-load-while-on diagnosis sequencer with its APB register slave.
// Assumes a single ref_clk domain; ch_on, pwm_map and ol_comp are
// synchronous to it; ol_comp is the comparator on the multiplexer output.
`timescale 1ns/1ps
`default_nettype none
`include "open_load_on_summary_flag_cfg.svh"

module open_load_on_summary_flag_diag_loop
    import open_load_on_summary_flag_pkg::*;
#(
    parameter logic [`CNT_W-1:0] SETTLE_CYC =
        `CNT_W'((`SETTLE_MAX_US * `NS_PER_US) / `CLK_PERIOD_NS),
    parameter logic [`CNT_W-1:0] SWITCH_CYC =
        `CNT_W'((`SWITCH_MAX_US * `NS_PER_US) / `CLK_PERIOD_NS),
    parameter logic [`CNT_W-1:0] PREMUX_CYC =
        `CNT_W'((`PREMUX_MAX_US * `NS_PER_US) / `CLK_PERIOD_NS),
    parameter logic [`CNT_W-1:0] SYNC_CYC   = `CNT_W'(`SYNC_CYC)
)(
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire logic [`ADDR_W-1:0] paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [`NCH-1:0]    ch_on,
    input  wire logic [2*`NCH-1:0]  pwm_map,
    input  wire logic               ol_comp,
    output logic      [`CH_W-1:0]   mux_ch,
    output logic                    mux_en,
    output logic      [`NCH-1:0]    open_load_on_result_bits,
    output logic                    open_load_on_summary_flag,
    output logic                    loop_busy
);

    localparam seq_reg_t SEQ_RESET = '{sel: `SEL_IDLE, st: ST_IDLE,
                                        ph: PH_DIRECT, default: '0};

    seq_reg_t        q;
    seq_reg_t        d;
    logic [`NCH-1:0] dmask;
    logic [`NCH-1:0] g0mask;
    logic [`NCH-1:0] g1mask;
    logic            acc;
    logic            setup;
    logic            wr_sel;
    logic            start;
    logic            settled;
    logic            advance;
    logic            fresh;
    phase_t          sph;
    logic [3:0]      base;
    logic [3:0]      nd;
    logic [3:0]      n0;
    logic [3:0]      n1;
    logic [3:0]      np;
    logic [`NCH-1:0] fresh_bits;

    delay_if tif ();
    mux_if   mif ();

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    open_load_on_summary_flag_delay_timer u_timer (
        .ref_clk (ref_clk),
        .srst    (srst),
        .tif     (tif)
    );

    open_load_on_summary_flag_ch_monitor u_mon (
        .ref_clk (ref_clk),
        .srst    (srst),
        .ch_on   (ch_on),
        .ol_comp (ol_comp),
        .mif     (mif)
    );

    assign tif.load  = q.tload;
    assign tif.count = q.tcount;
    assign mif.ch    = q.ch;

    function automatic logic is_single(input logic [`SEL_W-1:0] s);
        return (s >= `SEL_CH_LO) && (s <= `SEL_CH_HI);
    endfunction

    // Lowest set channel at or above from; bit 3 flags a hit
    function automatic logic [3:0] pick(input logic [`NCH-1:0] m,
                                        input logic [3:0]      from);
        logic [3:0] r;
        r = `NO_PICK;
        for (int i = `NCH - 1; i >= 0; i--) begin
            if (m[i] && (4'(i) >= from)) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // Only high-side capable channels take part, grouped by their driver
    for (genvar gi = 0; gi < `NCH; gi++) begin : g_map
        localparam logic HS = (gi >= `HS_FIRST);
        assign dmask[gi]  = HS && (pwm_map[`MAP_W*gi +: `MAP_W] == `MAP_DIRECT);
        assign g0mask[gi] = HS && (pwm_map[`MAP_W*gi +: `MAP_W] == `MAP_GEN0);
        assign g1mask[gi] = HS && (pwm_map[`MAP_W*gi +: `MAP_W] == `MAP_GEN1);
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode and next channel search

    assign setup   = psel & ~penable;
    assign acc     = psel & penable & q.pready;
    assign wr_sel  = acc & pwrite & (paddr == `ADDR_SEL);
    assign start   = wr_sel & (pwdata[`SEL_W-1:0] == `SEL_LOOP);
    assign settled = start ? 1'b0 : q.pwm_settled;
    assign fresh   = ch_on[q.ch] & mif.comp;
    assign fresh_bits = `NCH'(fresh) << q.ch;

    assign sph  = start ? PH_DIRECT : q.ph;
    assign base = start ? `HS_FIRST : ({1'b0, q.ch} + `CH_STEP);
    assign nd   = pick(dmask, (sph == PH_DIRECT) ? base : `FROM_NONE);
    assign n0   = pick(g0mask, (sph == PH_DIRECT) ? `HS_FIRST :
                               (sph == PH_GEN0) ? base : `FROM_NONE);
    assign n1   = pick(g1mask, (sph == PH_GEN1) ? base : `HS_FIRST);
    assign np   = n0[3] ? n0 : n1;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and registers

    always_comb begin
        d         = q;
        d.tload   = 1'b0;
        d.pready  = setup;
        advance   = 1'b0;

        case (q.st)
            ST_IDLE: begin
            end
            ST_D_WAIT: begin
                if (tif.done) begin
                    d.res[q.ch] = fresh;
                    advance     = 1'b1;
                end
            end
            ST_P_SETTLE: begin
                if (tif.done) begin
                    d.st = ST_P_ARM;
                end
            end
            ST_P_ARM: begin
                if (mif.on_rise) begin
                    d.tload  = 1'b1;
                    d.tcount = `CNT_W'(PREMUX_CYC + SWITCH_CYC);
                    d.st     = ST_P_MEAS;
                end
            end
            ST_P_MEAS: begin
                if (!ch_on[q.ch]) begin
                    d.res[q.ch] = 1'b0;
                    advance     = 1'b1;
                end else if (tif.done) begin
                    d.res[q.ch] = fresh;
                    advance     = 1'b1;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        if (wr_sel) begin
            d.sel    = pwdata[`SEL_W-1:0];
            d.st     = ST_IDLE;
            d.busy   = 1'b0;
            d.mux_en = is_single(pwdata[`SEL_W-1:0]);
            if (is_single(pwdata[`SEL_W-1:0])) begin
                d.ch  = pwdata[`CH_W-1:0];
                d.res = '0;
            end
            if (start) begin
                d.res         = '0;
                d.busy        = 1'b1;
                d.mux_en      = 1'b1;
                d.pwm_settled = 1'b0;
                advance       = 1'b1;
            end
        end

        if (advance) begin
            if (nd[3]) begin
                d.ph     = PH_DIRECT;
                d.ch     = nd[`CH_W-1:0];
                d.st     = ST_D_WAIT;
                d.tload  = 1'b1;
                d.tcount = start ? `CNT_W'(SETTLE_CYC + SYNC_CYC)
                                 : `CNT_W'(SWITCH_CYC + SYNC_CYC);
            end else if (np[3]) begin
                d.ph = n0[3] ? PH_GEN0 : PH_GEN1;
                d.ch = np[`CH_W-1:0];
                if (!settled) begin
                    d.st          = ST_P_SETTLE;
                    d.tload       = 1'b1;
                    d.tcount      = SETTLE_CYC;
                    d.pwm_settled = 1'b1;
                end else if (ch_on[np[`CH_W-1:0]]) begin
                    d.st     = ST_P_MEAS;
                    d.tload  = 1'b1;
                    d.tcount = SWITCH_CYC;
                end else begin
                    d.st = ST_P_ARM;
                end
            end else begin
                d.st     = ST_IDLE;
                d.busy   = 1'b0;
                d.mux_en = 1'b0;
                d.sel    = `SEL_IDLE;
            end
        end

        // Summary flag by select mode
        if (q.sel == `SEL_LOOP) begin
            d.flag = |d.res;
        end else if (is_single(q.sel)) begin
            if (setup && !pwrite &&
                (paddr == `ADDR_STAT || paddr == `ADDR_RES)) begin
                d.flag = fresh;
            end
        end else if (q.sel != `SEL_IDLE) begin
            d.flag = 1'b0;
        end

        // Read data is prepared in the setup cycle
        if (setup) begin
            d.prdata  = '0;
            d.pslverr = 1'b0;
            case (paddr)
                `ADDR_SEL: begin
                    d.prdata = 32'(q.sel);
                end
                `ADDR_RES: begin
                    if (is_single(q.sel) && !pwrite) begin
                        d.res    = fresh_bits;
                        d.prdata = 32'(fresh_bits);
                    end else begin
                        d.prdata = 32'(q.res);
                    end
                end
                `ADDR_STAT: begin
                    d.prdata = 32'(q.flag)
                             | (32'(q.busy) << `STAT_BUSY_BIT)
                             | (32'(q.ch) << `STAT_CH_LSB);
                end
                default: begin
                    d.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= SEQ_RESET;
        end else begin
            q <= d;
        end
    end

    assign prdata                    = q.prdata;
    assign pready                    = q.pready;
    assign pslverr                   = q.pslverr;
    assign mux_ch                    = q.ch;
    assign mux_en                    = q.mux_en;
    assign open_load_on_result_bits  = q.res;
    assign open_load_on_summary_flag = q.flag;
    assign loop_busy                 = q.busy;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_direct_check;
        (q.st == ST_D_WAIT) && tif.done;
    endsequence

    sequence s_pwm_drop;
        (q.st == ST_P_MEAS) && !ch_on[q.ch];
    endsequence

    property p_reset;
        @(posedge ref_clk) disable iff (1'b0)
        srst |=> (q.sel == `SEL_IDLE) && !q.busy;
    endproperty
    a_reset: assert property (p_reset)
        else $error("select not idle after reset");

    property p_start;
        (start && (|(dmask | g0mask | g1mask)))
            |=> q.busy && (q.sel == `SEL_LOOP) && q.mux_en;
    endproperty
    a_start: assert property (p_start)
        else $error("loop did not start");

    property p_first;
        (start && dmask[2]) |=> (q.ch == 3'h2) && (q.st == ST_D_WAIT)
                                && (q.tcount == 16'(SETTLE_CYC + SYNC_CYC));
    endproperty
    a_first: assert property (p_first)
        else $error("loop did not begin on channel 2");

    property p_order;
        (q.busy && q.ph != PH_DIRECT && !wr_sel) |=> (q.st != ST_D_WAIT);
    endproperty
    a_order: assert property (p_order)
        else $error("direct check after pwm checks");

    property p_gen_order;
        (q.ph == PH_GEN1 && !wr_sel) |=> (q.ph != PH_GEN0);
    endproperty
    a_gen_order: assert property (p_gen_order)
        else $error("generator 0 after generator 1");

    property p_off_zero;
        (s_direct_check and !ch_on[q.ch]) |=> !q.res[$past(q.ch)];
    endproperty
    a_off_zero: assert property (p_off_zero)
        else $error("off direct channel not zero");

    property p_short;
        s_pwm_drop |=> !q.res[$past(q.ch)];
    endproperty
    a_short: assert property (p_short)
        else $error("short pwm on-time not zero");

    property p_revert;
        ($fell(q.busy) && !$past(wr_sel)) |-> (q.sel == `SEL_IDLE);
    endproperty
    a_revert: assert property (p_revert)
        else $error("select did not return to idle");

    property p_loop_or;
        (q.sel == `SEL_LOOP) |=> (q.flag == (|q.res));
    endproperty
    a_loop_or: assert property (p_loop_or)
        else $error("flag not OR of results");

    property p_hold;
        ((q.sel == `SEL_IDLE) ##1 (q.sel == `SEL_IDLE)) |-> $stable(q.flag)
                                                         && $stable(q.res);
    endproperty
    a_hold: assert property (p_hold)
        else $error("idle flag changed");

    property p_reserved;
        (!is_single(q.sel) && q.sel != `SEL_LOOP && q.sel != `SEL_IDLE)
            ##1 (q.sel == $past(q.sel)) |-> !q.flag;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved select flag not zero");

    property p_single;
        is_single(q.sel) ##1 is_single(q.sel) |->
            ((q.res & ~(`NCH'(1) << q.ch)) == '0);
    endproperty
    a_single: assert property (p_single)
        else $error("unselected result bit set");

endmodule // open_load_on_summary_flag_diag_loop

`default_nettype wire

/* verilog/open_load_on_summary_flag_if.sv */
// Carriers between the sequencer, its delay timer and its channel monitor.
// All parties share one clock.
`timescale 1ns/1ps
`default_nettype none
`include "open_load_on_summary_flag_cfg.svh"

interface delay_if;
    logic              load;
    logic [`CNT_W-1:0] count;
    logic              done;
    modport ctrl  (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface

interface mux_if;
    logic [`CH_W-1:0] ch;
    logic             on_rise;
    logic             comp;
    modport seq (output ch, input on_rise, input comp);
    modport mon (input ch, output on_rise, output comp);
endinterface

`default_nettype wire

/* verilog/open_load_on_summary_flag_pkg.sv */
// Types shared by the diagnosis sequencer and its helpers.
// Assumes open_load_on_summary_flag_cfg.svh is on the include path.
`include "open_load_on_summary_flag_cfg.svh"

package open_load_on_summary_flag_pkg;

    typedef enum logic [2:0] {
        ST_IDLE, ST_D_WAIT, ST_P_SETTLE, ST_P_ARM, ST_P_MEAS
    } seq_st_t;

    typedef enum logic [1:0] {PH_DIRECT, PH_GEN0, PH_GEN1} phase_t;

    typedef struct packed {
        logic [`SEL_W-1:0] sel;
        seq_st_t           st;
        phase_t            ph;
        logic [`CH_W-1:0]  ch;
        logic              pwm_settled;
        logic [`NCH-1:0]   res;
        logic              flag;
        logic              busy;
        logic              mux_en;
        logic              tload;
        logic [`CNT_W-1:0] tcount;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } seq_reg_t;

    typedef struct packed {
        logic [`CNT_W-1:0] cnt;
        logic              run;
        logic              done;
    } timer_reg_t;

    typedef struct packed {
        logic [`CH_W-1:0] ch_prev;
        logic             on_prev;
        logic             rise;
        logic             comp;
    } mon_reg_t;

endpackage
